// *** mbi_pkg.sv ***
// package: register map, field positions and carrier types for the mailbox interrupt logic
package mbi_pkg;

	localparam int          MBOX_CNT      = 16;
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 16;
	localparam int          LOCAL_ADDR_W  = 32;

	// internal register space offsets
	localparam logic [7:0]  PCI_WR_EN_OFF = 8'hD0;
	localparam logic [7:0]  PCI_RD_EN_OFF = 8'hD2;
	localparam logic [7:0]  LOC_WR_EN_OFF = 8'hD4;
	localparam logic [7:0]  LOC_RD_EN_OFF = 8'hD6;
	localparam logic [7:0]  WR_STAT_OFF   = 8'hD8;
	localparam logic [7:0]  RD_STAT_OFF   = 8'hDA;
	localparam logic [7:0]  LB_STAT_OFF   = 8'h76;
	// second space offset
	localparam logic [7:0]  HDI_EN_OFF    = 8'h40;

	localparam int          LB_MBOX_BIT   = 7;
	localparam int          HDI_LINES     = 3;
	localparam logic [15:0] HDI_MASK      = 16'h0007;
	localparam logic [15:0] EN_RESET      = 16'h0000;
	localparam logic [15:0] STAT_RESET    = 16'h0000;

	// local-bus word that covers mailboxes 0..3
	localparam logic [31:0] MBOX_LOCAL_ADDR = 32'h1C0000C0;
	localparam logic [15:0] MBOX_GROUP0     = 16'h000F;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic              space1;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} mbi_req_t;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [MBOX_CNT-1:0] mbox;
	} mbi_evt_t;

endpackage

// *** mbi_status.sv ***
// module: one bank of write-one-to-clear mailbox status bits
`timescale 1ns/1ps

module mbi_status #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] set_bits,
	input  wire logic             clr_wr,
	input  wire logic [WIDTH-1:0] clr_data,
	output logic      [WIDTH-1:0] status
);

	// =========================================
	// sticky bits
	logic [WIDTH-1:0] status_r;
	logic [WIDTH-1:0] status_nxt;
	logic [WIDTH-1:0] clr_bits;

	if (WIDTH < 1)
	begin : g_bad_width
		$error("mbi_status: WIDTH must be positive");
	end

	// zero in a data bit leaves that bit alone
	assign clr_bits   = clr_wr ? clr_data : '0;
	// set wins over clear so a same-cycle event is never lost
	assign status_nxt = (status_r & ~clr_bits) | set_bits;
	assign status     = status_r;

	always_ff @(posedge clk)
	begin
		if (rst)
			status_r <= '0;
		else
			status_r <= status_nxt;
	end

endmodule

// *** mbi_core.sv ***
// module: mailbox interrupt enables, status and summary for the bridge
`timescale 1ns/1ps
// =========================================

module mbi_core #(
	parameter int MBOX = mbi_pkg::MBOX_CNT
) (
	input  wire logic                              clk,
	input  wire logic                              rst,
	// register port of the internal and second spaces
	input  wire mbi_pkg::mbi_req_t                 req,
	output logic      [mbi_pkg::DATA_W-1:0]        rdata,
	// host-side mailbox accesses
	input  wire mbi_pkg::mbi_evt_t                 pci_evt,
	// local-bus accesses from the DSP
	input  wire logic                              loc_wr,
	input  wire logic                              loc_rd,
	input  wire logic [mbi_pkg::LOCAL_ADDR_W-1:0]  loc_addr,
	input  wire logic                              host_irq_gate,
	output logic                                   host_irq,
	output logic                                   local_irq,
	output logic                                   dsp_irq_line0_enable,
	output logic                                   dsp_irq_line1_enable,
	output logic                                   dsp_irq_line2_enable
);

	// banks and enables share the one 16-bit register word
	if (MBOX != mbi_pkg::DATA_W)
	begin : g_bad_mbox
		$error("mbi_core: MBOX must equal the register width");
	end

	// =========================================
	// address decode
	logic wr0;
	logic wr1;
	logic hit_pci_wr_en;
	logic hit_pci_rd_en;
	logic hit_loc_wr_en;
	logic hit_loc_rd_en;
	logic hit_wr_stat;
	logic hit_rd_stat;
	logic hit_lb_stat;
	logic hit_hdi;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	assign wr0           = req.wr && !req.space1;
	assign wr1           = req.wr && req.space1;
	assign hit_pci_wr_en = hit(req.addr, mbi_pkg::PCI_WR_EN_OFF);
	assign hit_pci_rd_en = hit(req.addr, mbi_pkg::PCI_RD_EN_OFF);
	assign hit_loc_wr_en = hit(req.addr, mbi_pkg::LOC_WR_EN_OFF);
	assign hit_loc_rd_en = hit(req.addr, mbi_pkg::LOC_RD_EN_OFF);
	assign hit_wr_stat   = hit(req.addr, mbi_pkg::WR_STAT_OFF);
	assign hit_rd_stat   = hit(req.addr, mbi_pkg::RD_STAT_OFF);
	assign hit_lb_stat   = hit(req.addr, mbi_pkg::LB_STAT_OFF);
	assign hit_hdi       = hit(req.addr, mbi_pkg::HDI_EN_OFF);

	// =========================================
	// enable registers
	logic [MBOX-1:0] pci_wr_en_r;
	logic [MBOX-1:0] pci_rd_en_r;
	logic [MBOX-1:0] loc_wr_en_r;
	logic [MBOX-1:0] loc_rd_en_r;
	logic [mbi_pkg::HDI_LINES-1:0] hdi_en_r;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pci_wr_en_r <= mbi_pkg::EN_RESET;
			pci_rd_en_r <= mbi_pkg::EN_RESET;
			loc_wr_en_r <= mbi_pkg::EN_RESET;
			loc_rd_en_r <= mbi_pkg::EN_RESET;
			hdi_en_r    <= '0;
		end
		else
		begin
			if (wr0 && hit_pci_wr_en)
				pci_wr_en_r <= req.wdata;
			if (wr0 && hit_pci_rd_en)
				pci_rd_en_r <= req.wdata;
			if (wr0 && hit_loc_wr_en)
				loc_wr_en_r <= req.wdata;
			if (wr0 && hit_loc_rd_en)
				loc_rd_en_r <= req.wdata;
			if (wr1 && hit_hdi)
				hdi_en_r <= req.wdata[mbi_pkg::HDI_LINES-1:0];
		end
	end

	// =========================================
	// mailbox events
	logic            loc_hit;
	logic [MBOX-1:0] loc_wr_set;
	logic [MBOX-1:0] loc_rd_set;
	logic [MBOX-1:0] pci_wr_set;
	logic [MBOX-1:0] pci_rd_set;
	logic [MBOX-1:0] wr_set;
	logic [MBOX-1:0] rd_set;

	// one local word covers four mailboxes, all flagged together
	assign loc_hit    = (loc_addr == mbi_pkg::MBOX_LOCAL_ADDR);
	assign loc_wr_set = (loc_wr && loc_hit) ? mbi_pkg::MBOX_GROUP0 : '0;
	assign loc_rd_set = (loc_rd && loc_hit) ? mbi_pkg::MBOX_GROUP0 : '0;
	assign pci_wr_set = pci_evt.wr ? pci_evt.mbox : '0;
	assign pci_rd_set = pci_evt.rd ? pci_evt.mbox : '0;
	// status records every access; enables act on the interrupt outputs
	assign wr_set     = loc_wr_set | pci_wr_set;
	assign rd_set     = loc_rd_set | pci_rd_set;

	// =========================================
	// status banks
	logic [MBOX-1:0] wr_stat;
	logic [MBOX-1:0] rd_stat;

	mbi_status #(
		.WIDTH    (MBOX)
	) u_wr_stat (
		.clk      (clk),
		.rst      (rst),
		.set_bits (wr_set),
		.clr_wr   (wr0 && hit_wr_stat),
		.clr_data (req.wdata),
		.status   (wr_stat)
	);

	mbi_status #(
		.WIDTH    (MBOX)
	) u_rd_stat (
		.clk      (clk),
		.rst      (rst),
		.set_bits (rd_set),
		.clr_wr   (wr0 && hit_rd_stat),
		.clr_data (req.wdata),
		.status   (rd_stat)
	);

	// =========================================
	// summary and interrupt outputs
	logic [MBOX-1:0] loc_pend;
	logic [MBOX-1:0] pci_pend;
	logic            any_pend;
	logic            host_irq_r;
	logic            local_irq_r;

	// status from local and host accesses alike gated by local enables toward the host
	assign loc_pend = (wr_stat & loc_wr_en_r) | (rd_stat & loc_rd_en_r);
	assign pci_pend = (wr_stat & pci_wr_en_r) | (rd_stat & pci_rd_en_r);
	// summary tracks raw status so clearing the bank clears it too
	assign any_pend = |(wr_stat | rd_stat);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			host_irq_r  <= 1'b0;
			local_irq_r <= 1'b0;
		end
		else
		begin
			host_irq_r  <= (|loc_pend) && host_irq_gate;
			local_irq_r <= |pci_pend;
		end
	end

	assign host_irq  = host_irq_r;
	assign local_irq = local_irq_r;

	assign dsp_irq_line0_enable = hdi_en_r[0];
	assign dsp_irq_line1_enable = hdi_en_r[1];
	assign dsp_irq_line2_enable = hdi_en_r[2];

	// =========================================
	// read mux, registered; reserved bits read zero
	logic [mbi_pkg::DATA_W-1:0] rsel;
	logic [mbi_pkg::DATA_W-1:0] rdata_r;
	logic [mbi_pkg::DATA_W-1:0] lb_word;
	logic [mbi_pkg::DATA_W-1:0] hdi_word;

	assign lb_word  = {8'h00, any_pend, 7'h00};
	assign hdi_word = {13'h0000, hdi_en_r};

	assign rsel = req.space1 ? (hit_hdi ? hdi_word : 16'h0000) :
		hit_pci_wr_en ? pci_wr_en_r :
		hit_pci_rd_en ? pci_rd_en_r :
		hit_loc_wr_en ? loc_wr_en_r :
		hit_loc_rd_en ? loc_rd_en_r :
		hit_wr_stat   ? wr_stat :
		hit_rd_stat   ? rd_stat :
		hit_lb_stat   ? lb_word : 16'h0000;

	always_ff @(posedge clk)
	begin
		if (rst)
			rdata_r <= 16'h0000;
		else if (req.rd)
			rdata_r <= rsel;
	end

	assign rdata = rdata_r;

endmodule

// *** mbi_monitor.sv ***
// checker: port-level assertions for the mailbox interrupt logic
`timescale 1ns/1ps
// ========
// checker
module mbi_monitor (
	input wire logic              clk,
	input wire logic              rst,
	input wire mbi_pkg::mbi_req_t req,
	input wire logic [15:0]       rdata,
	input wire logic              host_irq_gate,
	input wire logic              host_irq,
	input wire logic              dsp_irq_line0_enable,
	input wire logic              dsp_irq_line1_enable,
	input wire logic              dsp_irq_line2_enable
);
	wire [2:0] ln = {dsp_irq_line2_enable, dsp_irq_line1_enable, dsp_irq_line0_enable};
	wire       ln_wr = req.wr && req.space1 && req.addr == mbi_pkg::HDI_EN_OFF;
	wire       ln_rd = req.rd && req.space1 && req.addr == mbi_pkg::HDI_EN_OFF;
	wire       sum_rd = req.rd && !req.space1 && req.addr == mbi_pkg::LB_STAT_OFF;
	wire       gap_rd = req.rd && !req.space1 && req.addr == 8'h00;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// a clear landing just before the read may hide the request
	sequence s_pend_rd;
		!req.wr ##1 host_irq && sum_rd;
	endsequence
	a_line_load: assert property (ln_wr |=> ln == $past(req.wdata[2:0]))
		else $error("line load");
	a_line_hold: assert property (!ln_wr |=> $stable(ln))
		else $error("line hold");
	a_line_readback: assert property (ln_rd |=> rdata[2:0] == $past(ln))
		else $error("line readback");
	a_reserved_zero: assert property (ln_rd |=> rdata[15:3] == 13'h0000)
		else $error("reserved bits");
	a_unmapped_zero: assert property (gap_rd |=> rdata == 16'h0000)
		else $error("unmapped read");
	a_summary_read: assert property (s_pend_rd |=> rdata[7])
		else $error("summary bit");
	a_gate_low: assert property (!host_irq_gate |=> !host_irq)
		else $error("gate low");
	// a clear reaches the output two edges after its write
	a_irq_fall: assert property ($fell(host_irq) |->
		!$past(host_irq_gate) || $past(req.wr) || $past(req.wr, 2))
		else $error("irq fall");
endmodule
bind mbi_core mbi_monitor mon (.clk, .rst, .req, .rdata, .host_irq_gate, .host_irq,
	.dsp_irq_line0_enable, .dsp_irq_line1_enable, .dsp_irq_line2_enable);

// *** mbi_dsp_model.sv ***
// partner model: DSP side issuing local-bus mailbox accesses
`timescale 1ns/1ps
module mbi_dsp_model (
	input  wire logic   clk,
	input  wire logic   go_wr,
	input  wire logic   go_rd,
	output logic        loc_wr = 1'h0,
	output logic        loc_rd = 1'h0,
	output logic [31:0] loc_addr = 32'h0
);
	// address wanders between accesses so a stale match cannot pass
	always @(posedge clk)
	begin
		loc_wr <= go_wr;
		loc_rd <= go_rd;
		loc_addr <= (go_wr || go_rd) ? mbi_pkg::MBOX_LOCAL_ADDR : ~loc_addr;
	end
endmodule

// *** mbi_core_tb_top.sv ***
// testbench: register table rows, then mailbox event and clear cases
`timescale 1ns/1ps
module mbi_core_tb_top;
	typedef struct {logic s; logic [7:0] a; logic [15:0] w; logic [15:0] r;} mbi_row_t;
	logic              clk = 1'h0;
	logic              rst = 1'h1;
	logic              host_irq_gate = 1'h0;
	logic              go_wr = 1'h0;
	logic              go_rd = 1'h0;
	logic              loc_wr, loc_rd, host_irq, local_irq;
	logic              dsp_irq_line0_enable, dsp_irq_line1_enable, dsp_irq_line2_enable;
	logic [31:0]       loc_addr;
	logic [15:0]       rdata;
	logic [15:0]       lines_w;
	mbi_pkg::mbi_req_t req = '0;
	mbi_pkg::mbi_evt_t pci_evt = '0;
	int                err_count = 0;
	int                checked = 0;
	mbi_row_t          rows [8] = '{
		'{1'h0, 8'hD4, 16'hFFFF, 16'hFFFF}, '{1'h0, 8'hD6, 16'h5A5A, 16'h5A5A},
		'{1'h0, 8'hD0, 16'h1234, 16'h1234}, '{1'h0, 8'hD2, 16'h8001, 16'h8001},
		'{1'h1, 8'h40, 16'hFFFF, 16'h0007}, '{1'h0, 8'h00, 16'h1234, 16'h0000},
		'{1'h0, 8'h76, 16'hFFFF, 16'h0000}, '{1'h0, 8'hD8, 16'hFFFF, 16'h0000}};
	mbi_core uut (.clk, .rst, .req, .rdata, .pci_evt, .loc_wr, .loc_rd, .loc_addr,
		.host_irq_gate, .host_irq, .local_irq, .dsp_irq_line0_enable,
		.dsp_irq_line1_enable, .dsp_irq_line2_enable);
	mbi_dsp_model far_dsp (.clk, .go_wr, .go_rd, .loc_wr, .loc_rd, .loc_addr);
	assign lines_w = {13'h0000, dsp_irq_line2_enable, dsp_irq_line1_enable, dsp_irq_line0_enable};
	// ========
	// tasks
	task automatic cmp(string n, logic [15:0] e, logic [15:0] g);
		checked++;
		if (g !== e)
		begin
			err_count++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic acc(logic w, logic s, logic [7:0] a, logic [15:0] d);
		@(posedge clk) #1;
		req = '{wr: w, rd: !w, space1: s, addr: a, wdata: d};
		@(posedge clk) #1;
		req = '0;
	endtask
	task automatic rd(logic [7:0] a, logic [15:0] e, string n);
		acc(1'h0, 1'h0, a, 16'h0000);
		cmp(n, e, rdata);
	endtask
	task automatic irq(logic h, logic l, string n);
		repeat (2) @(posedge clk);
		#1;
		cmp(n, {14'h0000, h, l}, {14'h0000, host_irq, local_irq});
	endtask
	task automatic dsp_acc(logic w);
		@(posedge clk) #1;
		{go_wr, go_rd} = {w, !w};
		@(posedge clk) #1;
		{go_wr, go_rd} = 2'h0;
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ========
	// stimulus
	initial
		forever #5 clk = ~clk;
	initial
	begin
		#100000;
		err_count++;
		print_verdict();
	end
	initial
	begin
		repeat (20) @(posedge clk);
		#1 rst = 1'h0;
		rd(8'hD4, 16'h0000, "enable reset");
		rd(8'hDA, 16'h0000, "status reset");
		$display("test reset done");
		foreach (rows[i])
		begin
			acc(1'h1, rows[i].s, rows[i].a, rows[i].w);
			acc(1'h0, rows[i].s, rows[i].a, 16'h0000);
			cmp("row", rows[i].r, rdata);
		end
		cmp("lines", 16'h0007, lines_w);
		$display("test table done");
		acc(1'h1, 1'h0, 8'hD4, 16'h0001);
		host_irq_gate = 1'h1;
		dsp_acc(1'h1);
		irq(1'h1, 1'h1, "dsp write irq");
		rd(8'hD8, 16'h000F, "write status");
		rd(8'hDA, 16'h0000, "read status");
		rd(8'h76, 16'h0080, "summary set");
		acc(1'h1, 1'h0, 8'hD8, 16'h0001);
		irq(1'h0, 1'h1, "clear irq");
		rd(8'hD8, 16'h000E, "partial clear");
		acc(1'h1, 1'h0, 8'hD8, 16'hFFFF);
		rd(8'h76, 16'h0000, "summary clear");
		dsp_acc(1'h0);
		irq(1'h1, 1'h1, "dsp read irq");
		rd(8'hDA, 16'h000F, "read status set");
		host_irq_gate = 1'h0;
		irq(1'h0, 1'h1, "gate closed");
		acc(1'h1, 1'h0, 8'hDA, 16'hFFFF);
		pci_evt = '{wr: 1'h1, rd: 1'h0, mbox: 16'h8000};
		@(posedge clk) #1;
		pci_evt = '0;
		irq(1'h0, 1'h0, "pci unenabled");
		acc(1'h1, 1'h0, 8'hD0, 16'h8000);
		irq(1'h0, 1'h1, "pci late enable");
		rd(8'hD8, 16'h8000, "pci status");
		acc(1'h1, 1'h0, 8'hD8, 16'hFFFF);
		pci_evt = '{wr: 1'h0, rd: 1'h1, mbox: 16'h0001};
		@(posedge clk) #1;
		pci_evt = '0;
		irq(1'h0, 1'h1, "pci read irq");
		rd(8'hDA, 16'h0001, "pci read status");
		// clear and event in one cycle: the event must survive
		@(posedge clk) #1;
		req = '{wr: 1'h1, rd: 1'h0, space1: 1'h0, addr: 8'hDA, wdata: 16'hFFFF};
		pci_evt = '{wr: 1'h0, rd: 1'h1, mbox: 16'h0001};
		@(posedge clk) #1;
		req = '0;
		pci_evt = '0;
		rd(8'hDA, 16'h0001, "set beats clear");
		$display("test events done");
		@(posedge clk) #1;
		rst = 1'h1;
		repeat (2) @(posedge clk);
		#1 rst = 1'h0;
		cmp("irq after reset", 16'h0000, {14'h0000, host_irq, local_irq});
		cmp("lines after reset", 16'h0000, lines_w);
		cmp("rdata after reset", 16'h0000, rdata);
		rd(8'hD6, 16'h0000, "enable cleared");
		rd(8'hDA, 16'h0000, "status cleared");
		$display("test reset again done");
		print_verdict();
	end
endmodule
